//--- hdl/rsw_bus_if.sv
/*
 Two-wire serial control link between the bus master and the switch device,
 plus the interface supply level that the master controls.
 Assumes the bus keeper holds the data wire low while nobody drives it.
*/
`timescale 1ns/1ps
interface rsw_bus_if;
   logic vio;
   logic sclk;
   logic m_sdata_out;
   logic m_sdata_oe;
   logic s_sdata_out;
   logic s_sdata_oe;
   logic sdata;

   assign sdata = m_sdata_oe ? m_sdata_out : (s_sdata_oe ? s_sdata_out : 1'b0);

   modport master (output vio, output sclk, output m_sdata_out, output m_sdata_oe,
                   input sdata);
   modport slave (input vio, input sclk, input sdata, output s_sdata_out,
                  output s_sdata_oe);
endinterface : rsw_bus_if

//--- hdl/rsw_master.sv
/*
 Master end: issues register write and read sequences over the serial link, makes
 the bus clock by division, and controls the device's interface supply.
 Assumes one device on the link, addressed by USID.
*/
`timescale 1ns/1ps
module rsw_master #(
   parameter int HALF_CYC = 4,
   parameter logic [3:0] USID = rsw_pkg::USID_RESET
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial link
   rsw_bus_if.master bus,
   // Command request
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [4:0] cmd_addr,
   input wire logic [7:0] cmd_data,
   output logic cmd_ready,
   input wire logic vio_cycle_req,
   // Response
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_parity_err
);
   typedef enum logic [2:0] {
      H_VIO_OFF = 3'b000,
      H_VIO_WAIT = 3'b001,
      H_IDLE = 3'b010,
      H_GAP = 3'b011,
      H_SSC_HI = 3'b100,
      H_SSC_LO = 3'b101,
      H_BITS = 3'b110
   } rsw_host_t;
   localparam int WAIT_W = $clog2(rsw_pkg::VIO_WAIT_CYC + 1);

   rsw_host_t st, next_st;
   logic [WAIT_W-1:0] wait_cnt, next_wait_cnt, gap_cnt, next_gap_cnt;
   logic [7:0] tmr, next_tmr;
   logic [4:0] k, next_k;
   logic [21:0] frame, next_frame;
   logic [8:0] rx, next_rx;
   logic wr_q, next_wr_q, sw_q, next_sw_q;
   logic sda_m, sda_s;
   logic vio, next_vio, sclk, next_sclk, sdo, next_sdo, oe, next_oe;
   logic next_ready, next_rsp_valid, next_rsp_err;
   logic [7:0] next_rsp_data;

   always_comb begin
      logic [4:0] last;
      last = wr_q ? rsw_pkg::LAST_WR + 5'h01 : rsw_pkg::RD_END;
      next_st = st;
      next_wait_cnt = (wait_cnt != '0) ? wait_cnt - WAIT_W'(1) : wait_cnt;
      next_gap_cnt = (gap_cnt != '0) ? gap_cnt - WAIT_W'(1) : gap_cnt;
      next_tmr = (tmr != 8'h00) ? tmr - 8'h01 : tmr;
      next_k = k;
      next_frame = frame;
      next_rx = rx;
      next_wr_q = wr_q;
      next_sw_q = sw_q;
      next_vio = vio;
      next_sclk = sclk;
      next_sdo = sdo;
      next_oe = oe;
      next_rsp_valid = 1'b0;
      next_rsp_data = rsp_data;
      next_rsp_err = rsp_parity_err;
      case (st)
         H_VIO_OFF: begin
            next_vio = 1'b0;
            if (wait_cnt == '0) begin
               next_vio = 1'b1;
               next_wait_cnt = WAIT_W'(rsw_pkg::VIO_WAIT_CYC - 1);
               next_st = H_VIO_WAIT;
            end
         end
         H_VIO_WAIT: if (wait_cnt == '0) next_st = H_IDLE;
         H_IDLE: begin
            if (cmd_valid) begin
               next_wr_q = cmd_write;
               next_sw_q = cmd_write && (cmd_addr == rsw_pkg::ADDR_BANK_A ||
                                         cmd_addr == rsw_pkg::ADDR_BANK_B);
               next_frame[21:9] = {USID, cmd_write ? rsw_pkg::CMD_WRITE : rsw_pkg::CMD_READ,
                                   cmd_addr, ~^{USID, cmd_write, cmd_addr}};
               next_frame[8:0] = {cmd_data, ~^cmd_data};
               next_st = H_GAP;
            end else if (vio_cycle_req) begin
               next_wait_cnt = WAIT_W'(rsw_pkg::VIO_LOW_CYC - 1);
               next_vio = 1'b0;
               next_st = H_VIO_OFF;
            end
         end
         H_GAP: begin
            if (!sw_q || gap_cnt == '0) begin
               next_sdo = 1'b1;
               next_tmr = 8'(HALF_CYC - 1);
               next_st = H_SSC_HI;
            end
         end
         H_SSC_HI: begin
            if (tmr == 8'h00) begin
               next_sdo = 1'b0;
               next_tmr = 8'(HALF_CYC - 1);
               next_k = 5'h00;
               next_st = H_SSC_LO;
            end
         end
         H_SSC_LO, H_BITS: begin
            if (tmr == 8'h00) begin
               next_tmr = 8'(HALF_CYC - 1);
               next_st = H_BITS;
               if (st == H_SSC_LO || !sclk) begin
                  // Read data is taken just before the rise, the device's latest change.
                  if (!wr_q && k > rsw_pkg::RD_FIRST) next_rx = {rx[7:0], sda_s};
                  next_sclk = 1'b1;
                  next_oe = 1'b1;
                  if (k <= rsw_pkg::LAST_CMD || (wr_q && k <= rsw_pkg::LAST_WR)) begin
                     next_sdo = frame[5'd21 - k];
                  end else if (k == rsw_pkg::RD_LOAD && !wr_q) begin
                     next_sdo = 1'b0;
                  end else if (!wr_q && k < rsw_pkg::RD_END) begin
                     next_oe = 1'b0;
                  end else begin
                     next_sdo = 1'b0;
                  end
               end else begin
                  next_sclk = 1'b0;
                  next_k = k + 5'h01;
                  if (k == last) begin
                     next_oe = 1'b1;
                     next_sdo = 1'b0;
                     next_rsp_valid = 1'b1;
                     next_rsp_data = wr_q ? frame[8:1] : next_rx[8:1];
                     next_rsp_err = !wr_q && ~^next_rx;
                     if (sw_q) next_gap_cnt = WAIT_W'(rsw_pkg::SWITCH_GAP_CYC);
                     next_st = H_IDLE;
                  end
               end
            end
         end
         default: next_st = H_IDLE;
      endcase
      next_ready = (next_st == H_IDLE);
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st <= H_VIO_OFF;
         wait_cnt <= WAIT_W'(rsw_pkg::VIO_LOW_CYC - 1);
         gap_cnt <= '0;
         tmr <= 8'h00;
         k <= 5'h00;
         frame <= '0;
         rx <= 9'h000;
         {wr_q, sw_q, vio, sclk, sdo, oe} <= 6'h01;
         {sda_m, sda_s} <= 2'h0;
         cmd_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_parity_err <= 1'b0;
      end else begin
         st <= next_st;
         wait_cnt <= next_wait_cnt;
         gap_cnt <= next_gap_cnt;
         tmr <= next_tmr;
         k <= next_k;
         frame <= next_frame;
         rx <= next_rx;
         {wr_q, sw_q, vio, sclk, sdo, oe} <= {next_wr_q, next_sw_q, next_vio, next_sclk, next_sdo, next_oe};
         sda_m <= bus.sdata;
         sda_s <= sda_m;
         cmd_ready <= next_ready;
         rsp_valid <= next_rsp_valid;
         rsp_data <= next_rsp_data;
         rsp_parity_err <= next_rsp_err;
      end
   end

   assign bus.vio = vio;
   assign bus.sclk = sclk;
   assign bus.m_sdata_out = sdo;
   assign bus.m_sdata_oe = oe;
endmodule : rsw_master

//--- hdl/rsw_pkg.sv
/*
 Shared constants of the antenna switch serial control link: register map, field
 positions, reset values, frame layout and timing counts.
 Assumes a 25 MHz reference clock at both ends of the link.
*/
package rsw_pkg;
   // Reference clock and timing figures.
   localparam int CLK_MHZ = 25;
   localparam int SWITCH_GAP_US = 20;
   localparam int VIO_LOW_US = 10;
   localparam int VIO_WAIT_US = 120;
   localparam int STARTUP_SETTLE_US = 10;
   localparam int STARTUP_MAX_US = 20;
   localparam int SWITCH_GAP_CYC = SWITCH_GAP_US * CLK_MHZ;
   localparam int VIO_LOW_CYC = VIO_LOW_US * CLK_MHZ;
   localparam int VIO_WAIT_CYC = VIO_WAIT_US * CLK_MHZ;
   localparam int STARTUP_CYC = STARTUP_SETTLE_US * CLK_MHZ;
   localparam int STARTUP_MAX_CYC = STARTUP_MAX_US * CLK_MHZ;
   // Register addresses.
   localparam logic [4:0] ADDR_BANK_B = 5'h00;
   localparam logic [4:0] ADDR_BANK_A = 5'h01;
   localparam logic [4:0] ADDR_STATUS = 5'h1A;
   localparam logic [4:0] ADDR_GSID = 5'h1B;
   localparam logic [4:0] ADDR_PWR_TRIG = 5'h1C;
   localparam logic [4:0] ADDR_PRODUCT = 5'h1D;
   localparam logic [4:0] ADDR_MFR_LO = 5'h1E;
   localparam logic [4:0] ADDR_MFR_HI = 5'h1F;
   // Reset values.
   localparam logic [7:0] BANK_RESET = 8'h00;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [2:0] TRIG_DIS_RESET = 3'h0;
   localparam logic [3:0] GSID_RESET = 4'h0;
   localparam logic [3:0] USID_RESET = 4'hA;
   // Field positions.
   localparam int PATH_W = 5;
   localparam int PWR_LSB = 6;
   localparam int TRIG_DIS_LSB = 3;
   localparam int ST_SW_RESET = 7;
   localparam int ST_CMD_PAR = 6;
   localparam int ST_DATA_PAR = 3;
   localparam int ST_RD_UNUSED = 2;
   localparam int ST_WR_UNUSED = 1;
   // Power state field codes.
   localparam logic [1:0] PWR_ACTIVE = 2'h0;
   localparam logic [1:0] PWR_STARTUP = 2'h1;
   localparam logic [1:0] PWR_LOW = 2'h2;
   // Command codes and frame bit positions, counted in falling clock edges.
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_READ = 3'h3;
   localparam logic [4:0] LAST_CMD = 5'h0C;
   localparam logic [4:0] RD_LOAD = 5'h0D;
   localparam logic [4:0] RD_FIRST = 5'h0E;
   localparam logic [4:0] LAST_WR = 5'h15;
   localparam logic [4:0] RD_LAST = 5'h16;
   localparam logic [4:0] RD_END = 5'h17;

   typedef enum logic [1:0] {
      RSW_SHUTDOWN = 2'b00,
      RSW_STARTUP = 2'b01,
      RSW_ACTIVE = 2'b10,
      RSW_LOW_POWER = 2'b11
   } rsw_power_t;
endpackage : rsw_pkg

//--- hdl/rsw_slave.sv
/*
 Device end: serial slave controller, register file and operating state of the
 dual five-throw antenna switch.
 Assumes the master makes the bus clock slower than a quarter of ref_clk.
*/
`timescale 1ns/1ps
// Contract
// - Exactly one of four operating states is current.
// - States change by power field write or supply.
// - Entering startup loads every register default.
// - Charge pump and switch follow only when active.
// - Incoming data captured on falling bus clock.
// - Read data changes only on rising edges.
// - Master spaces switch writes by 20 us.
// - Startup reaches active, or low if written, within 20 us.
// - Supply reset holds supply low 10 us.
// - Master waits 120 us after supply reset.
// - Switch registers use low five path bits.
// - Power field codes select active, startup, low.
// - Master disables triggers before programming switches.
// - Trigger bits disable; write ones load pending.
module rsw_slave #(
   parameter logic [7:0] PRODUCT_ID = 8'h5A, // Arbitrary identity value.
   parameter logic [9:0] MFR_ID = 10'h155 // Arbitrary identity value.
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial link
   rsw_bus_if.slave bus,
   // Switch core
   output logic [rsw_pkg::PATH_W-1:0] antenna_common_first_bank,
   output logic [rsw_pkg::PATH_W-1:0] antenna_common_second_bank,
   output logic charge_pump_on,
   output rsw_pkg::rsw_power_t power_state
);
   localparam int SET_W = $clog2(rsw_pkg::STARTUP_CYC + 1);
   localparam logic [SET_W-1:0] SETTLE_LOAD = SET_W'(rsw_pkg::STARTUP_CYC - 1);

   logic sclk_m, sclk_s, sclk_d, sda_m, sda_s, sda_d, vio_m, vio_s;
   rsw_pkg::rsw_power_t pstate, next_pstate;
   logic [SET_W-1:0] settle, next_settle;
   logic to_low, next_to_low;
   logic armed, next_armed, in_frame, next_in_frame, is_read, next_is_read;
   logic [4:0] cnt, next_cnt, addr, next_addr;
   logic [20:0] shreg, next_shreg;
   logic [8:0] rd_word, next_rd_word;
   logic sdo, next_sdo, sdo_oe, next_sdo_oe;
   logic [7:0] bank_a, next_bank_a, bank_b, next_bank_b;
   logic [7:0] live_a, next_live_a, live_b, next_live_b, status, next_status;
   logic [2:0] trig_dis, next_trig_dis;
   logic [3:0] gsid, next_gsid, usid, next_usid;
   logic [rsw_pkg::PATH_W-1:0] next_out_a, next_out_b;

   wire sclk_fall = sclk_d & ~sclk_s;
   wire sclk_rise = ~sclk_d & sclk_s;
   wire ssc_high = ~sclk_d & ~sclk_s & ~sda_d & sda_s;
   wire ssc_low = ~sclk_d & ~sclk_s & sda_d & ~sda_s;
   wire bus_on = vio_s & (pstate == rsw_pkg::RSW_ACTIVE || pstate == rsw_pkg::RSW_LOW_POWER);

   // Pins come from another domain; only the second and third stages feed logic.
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         {sclk_m, sclk_s, sclk_d, sda_m, sda_s, sda_d, vio_m, vio_s} <= 8'h00;
      end else begin
         sclk_m <= bus.sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         sda_m <= bus.sdata;
         sda_s <= sda_m;
         sda_d <= sda_s;
         vio_m <= bus.vio;
         vio_s <= vio_m;
      end
   end

   always_comb begin
      logic [21:0] word;
      logic [7:0] rv;
      logic [7:0] d;
      logic [7:0] err;
      logic wr;
      logic defaults;
      word = {shreg, sda_s};
      d = word[8:1];
      rv = 8'h00;
      err = 8'h00;
      wr = 1'b0;
      defaults = 1'b0;
      next_pstate = pstate;
      next_settle = settle;
      next_to_low = to_low;
      next_armed = armed;
      next_in_frame = in_frame;
      next_is_read = is_read;
      next_cnt = cnt;
      next_addr = addr;
      next_shreg = shreg;
      next_rd_word = rd_word;
      next_sdo = sdo;
      next_sdo_oe = sdo_oe;
      next_bank_a = bank_a;
      next_bank_b = bank_b;
      next_live_a = live_a;
      next_live_b = live_b;
      next_status = status;
      next_trig_dis = trig_dis;
      next_gsid = gsid;
      next_usid = usid;
      case (addr)
         rsw_pkg::ADDR_BANK_A: rv = bank_a;
         rsw_pkg::ADDR_BANK_B: rv = bank_b;
         rsw_pkg::ADDR_STATUS: rv = status;
         rsw_pkg::ADDR_GSID: rv = {4'h0, gsid};
         rsw_pkg::ADDR_PWR_TRIG: begin
            rv = {rsw_pkg::PWR_ACTIVE, trig_dis, 3'h0};
            if (pstate == rsw_pkg::RSW_LOW_POWER) rv[7:6] = rsw_pkg::PWR_LOW;
            if (pstate == rsw_pkg::RSW_STARTUP) rv[7:6] = rsw_pkg::PWR_STARTUP;
         end
         rsw_pkg::ADDR_PRODUCT: rv = PRODUCT_ID;
         rsw_pkg::ADDR_MFR_LO: rv = MFR_ID[7:0];
         rsw_pkg::ADDR_MFR_HI: rv = {2'h0, MFR_ID[9:8], usid};
         default: rv = 8'h00;
      endcase
      if (!bus_on) begin
         next_armed = 1'b0;
         next_in_frame = 1'b0;
         next_sdo = 1'b0;
         next_sdo_oe = 1'b0;
      end else if (ssc_high) begin
         next_armed = 1'b1;
      end else if (ssc_low && armed) begin
         next_armed = 1'b0;
         next_in_frame = 1'b1;
         next_cnt = 5'h00;
         next_sdo_oe = 1'b0;
      end else if (in_frame && sclk_fall) begin
         next_cnt = cnt + 5'h01;
         next_shreg = word[20:0];
         if (cnt == rsw_pkg::LAST_CMD) begin
            next_addr = word[5:1];
            next_is_read = (word[8:6] == rsw_pkg::CMD_READ);
            if (~^word[12:0]) begin
               err[rsw_pkg::ST_CMD_PAR] = 1'b1;
               next_in_frame = 1'b0;
            end else if (word[12:9] != usid ||
                         (word[8:6] != rsw_pkg::CMD_WRITE && word[8:6] != rsw_pkg::CMD_READ)) begin
               next_in_frame = 1'b0;
            end
         end else if (cnt == rsw_pkg::LAST_WR && !is_read) begin
            next_in_frame = 1'b0;
            if (~^word[8:0]) begin
               err[rsw_pkg::ST_DATA_PAR] = 1'b1;
            end else begin
               wr = 1'b1;
            end
         end
      end else if (in_frame && is_read && sclk_rise) begin
         if (cnt == rsw_pkg::RD_LOAD) begin
            next_rd_word = {rv, ~^rv};
            err[rsw_pkg::ST_RD_UNUSED] = (addr > rsw_pkg::ADDR_BANK_A &&
                                           addr < rsw_pkg::ADDR_STATUS);
         end else if (cnt >= rsw_pkg::RD_FIRST && cnt <= rsw_pkg::RD_LAST) begin
            next_sdo = rd_word[8];
            next_sdo_oe = 1'b1;
            next_rd_word = {rd_word[7:0], 1'b0};
         end else if (cnt >= rsw_pkg::RD_END) begin
            next_sdo = 1'b0;
            next_sdo_oe = 1'b0;
            next_in_frame = 1'b0;
         end
      end
      if (wr) begin
         case (addr)
            rsw_pkg::ADDR_BANK_A: begin
               next_bank_a = d;
               if (trig_dis[0]) next_live_a = d;
            end
            rsw_pkg::ADDR_BANK_B: begin
               next_bank_b = d;
               if (trig_dis[1]) next_live_b = d;
            end
            rsw_pkg::ADDR_STATUS: begin
               if (d[rsw_pkg::ST_SW_RESET]) defaults = 1'b1;
               next_status = rsw_pkg::STATUS_RESET;
            end
            rsw_pkg::ADDR_GSID: next_gsid = d[3:0];
            rsw_pkg::ADDR_PWR_TRIG: begin
               next_trig_dis = d[rsw_pkg::TRIG_DIS_LSB +: 3];
               if (d[0] || d[2]) next_live_a = bank_a;
               if (d[1] || d[2]) next_live_b = bank_b;
               case (d[rsw_pkg::PWR_LSB +: 2])
                  rsw_pkg::PWR_ACTIVE: next_pstate = rsw_pkg::RSW_ACTIVE;
                  rsw_pkg::PWR_LOW: next_pstate = rsw_pkg::RSW_LOW_POWER;
                  rsw_pkg::PWR_STARTUP: begin
                     next_pstate = rsw_pkg::RSW_STARTUP;
                     next_to_low = 1'b1;
                     next_settle = '0;
                     defaults = 1'b1;
                  end
                  default: next_pstate = pstate;
               endcase
            end
            rsw_pkg::ADDR_MFR_HI: next_usid = d[3:0];
            rsw_pkg::ADDR_PRODUCT, rsw_pkg::ADDR_MFR_LO: next_usid = usid;
            default: err[rsw_pkg::ST_WR_UNUSED] = 1'b1;
         endcase
      end
      // Error sets follow the clear so a coincident event is never lost.
      next_status = next_status | err;
      case (pstate)
         rsw_pkg::RSW_SHUTDOWN: begin
            if (vio_s) begin
               next_pstate = rsw_pkg::RSW_STARTUP;
               next_to_low = 1'b0;
               next_settle = SETTLE_LOAD;
               defaults = 1'b1;
            end
         end
         rsw_pkg::RSW_STARTUP: begin
            if (settle == '0) begin
               next_pstate = to_low ? rsw_pkg::RSW_LOW_POWER : rsw_pkg::RSW_ACTIVE;
            end else begin
               next_settle = settle - SET_W'(1);
            end
         end
         default: next_pstate = next_pstate;
      endcase
      if (!vio_s) begin
         next_pstate = rsw_pkg::RSW_SHUTDOWN;
         defaults = 1'b1;
      end
      if (defaults) begin
         next_bank_a = rsw_pkg::BANK_RESET;
         next_bank_b = rsw_pkg::BANK_RESET;
         next_live_a = rsw_pkg::BANK_RESET;
         next_live_b = rsw_pkg::BANK_RESET;
         next_status = rsw_pkg::STATUS_RESET;
         next_trig_dis = rsw_pkg::TRIG_DIS_RESET;
         next_gsid = rsw_pkg::GSID_RESET;
         next_usid = rsw_pkg::USID_RESET;
      end
      // Outside active the core is dark; in low power the written values stay for later.
      next_out_a = '0;
      next_out_b = '0;
      if (next_pstate == rsw_pkg::RSW_ACTIVE) begin
         next_out_a = next_live_a[rsw_pkg::PATH_W-1:0];
         next_out_b = next_live_b[rsw_pkg::PATH_W-1:0];
      end
   end

   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         pstate <= rsw_pkg::RSW_SHUTDOWN;
         settle <= '0;
         to_low <= 1'b0;
         {armed, in_frame, is_read, sdo, sdo_oe} <= 5'h00;
         cnt <= 5'h00;
         addr <= 5'h00;
         shreg <= '0;
         rd_word <= 9'h000;
         {bank_a, bank_b, live_a, live_b} <= {4{rsw_pkg::BANK_RESET}};
         status <= rsw_pkg::STATUS_RESET;
         trig_dis <= rsw_pkg::TRIG_DIS_RESET;
         gsid <= rsw_pkg::GSID_RESET;
         usid <= rsw_pkg::USID_RESET;
         antenna_common_first_bank <= '0;
         antenna_common_second_bank <= '0;
         charge_pump_on <= 1'b0;
      end else begin
         pstate <= next_pstate;
         settle <= next_settle;
         to_low <= next_to_low;
         {armed, in_frame, is_read, sdo, sdo_oe} <=
            {next_armed, next_in_frame, next_is_read, next_sdo, next_sdo_oe};
         cnt <= next_cnt;
         addr <= next_addr;
         shreg <= next_shreg;
         rd_word <= next_rd_word;
         {bank_a, bank_b, live_a, live_b} <= {next_bank_a, next_bank_b, next_live_a, next_live_b};
         status <= next_status;
         trig_dis <= next_trig_dis;
         gsid <= next_gsid;
         usid <= next_usid;
         antenna_common_first_bank <= next_out_a;
         antenna_common_second_bank <= next_out_b;
         charge_pump_on <= (next_pstate == rsw_pkg::RSW_ACTIVE);
      end
   end

   assign power_state = pstate;
   assign bus.s_sdata_out = sdo;
   assign bus.s_sdata_oe = sdo_oe;
endmodule : rsw_slave

//--- sim/rffe_switch_slave_control_tb.sv
/* Bench joining master and device over the link: table rows, then hand tests.
 Assumes both ends run on one 25 MHz ref_clk. */
`timescale 1ns/1ps
module rffe_switch_slave_control_tb;
   typedef struct packed {
      logic w;
      logic [4:0] a;
      logic [7:0] d;
      logic [7:0] r;
      logic [4:0] ba;
      logic [4:0] bb;
   } rsw_row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_write = 1'b0;
   logic [4:0] cmd_addr = 5'h00;
   logic [7:0] cmd_data = 8'h00;
   logic vio_cycle_req = 1'b0;
   logic cmd_ready, rsp_valid, rsp_parity_err, charge_pump_on;
   logic [7:0] rsp_data, rsp;
   logic [4:0] bank_a, bank_b;
   rsw_pkg::rsw_power_t power_state;
   int n_errors = 0;
   int cmp_count = 0;
   int cyc = 0;
   rsw_row_t rows [12] = '{'{1'b1, 5'h1C, 8'h38, 8'h38, 5'h00, 5'h00},
      '{1'b1, 5'h01, 8'hE1, 8'hE1, 5'h01, 5'h00}, '{1'b1, 5'h00, 8'h02, 8'h02, 5'h01, 5'h02},
      '{1'b1, 5'h01, 8'h04, 8'h04, 5'h04, 5'h02}, '{1'b1, 5'h00, 8'h07, 8'h07, 5'h04, 5'h07},
      '{1'b1, 5'h01, 8'h0B, 8'h0B, 5'h0B, 5'h07}, '{1'b1, 5'h00, 8'h00, 8'h00, 5'h0B, 5'h00},
      '{1'b0, 5'h1C, 8'h00, 8'h38, 5'h0B, 5'h00}, '{1'b0, 5'h01, 8'h00, 8'h0B, 5'h0B, 5'h00},
      '{1'b0, 5'h1F, 8'h00, 8'h1A, 5'h0B, 5'h00}, '{1'b1, 5'h05, 8'hFF, 8'hFF, 5'h0B, 5'h00},
      '{1'b0, 5'h1A, 8'h00, 8'h02, 5'h0B, 5'h00}};
   rsw_bus_if bus();
   rsw_master u_rsw_master (.ref_clk(ref_clk), .reset(reset), .bus(bus), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_ready(cmd_ready),
      .vio_cycle_req(vio_cycle_req), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_parity_err(rsp_parity_err));
   rsw_slave u_rsw_slave (.ref_clk(ref_clk), .reset(reset), .bus(bus),
      .antenna_common_first_bank(bank_a), .antenna_common_second_bank(bank_b),
      .charge_pump_on(charge_pump_on), .power_state(power_state));
   rsw_checker u_rsw_checker (.ref_clk(ref_clk), .reset(reset), .vio(bus.vio), .sclk(bus.sclk),
      .m_sdata_out(bus.m_sdata_out), .m_sdata_oe(bus.m_sdata_oe), .s_sdata_out(bus.s_sdata_out),
      .s_sdata_oe(bus.s_sdata_oe), .antenna_common_first_bank(bank_a),
      .charge_pump_on(charge_pump_on), .power_state(power_state));
   always #20 ref_clk = ~ref_clk;
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Every wait is cut short by the cycle ceiling below.
   task automatic cmd(input logic w, input logic [4:0] a, input logic [7:0] d);
      while (cmd_ready !== 1'b1) @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_write <= w;
      cmd_addr <= a;
      cmd_data <= d;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      do @(posedge ref_clk); while (rsp_valid !== 1'b1);
      rsp = rsp_data;
   endtask : cmd
   task automatic wait_st(input rsw_pkg::rsw_power_t s);
      while (power_state !== s) @(posedge ref_clk);
   endtask : wait_st
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk("state", 8'(power_state), 8'h00);
      wait_st(rsw_pkg::RSW_ACTIVE);
      repeat (2) @(posedge ref_clk);
      chk("pump", 8'(charge_pump_on), 8'h01);
      $display("test power-up done");
      foreach (rows[i]) begin
         cmd(rows[i].w, rows[i].a, rows[i].d);
         chk("rsp", rsp, rows[i].r);
         chk("perr", 8'(rsp_parity_err), 8'h00);
         chk("bank_a", 8'(bank_a), 8'(rows[i].ba));
         chk("bank_b", 8'(bank_b), 8'(rows[i].bb));
      end
      $display("test rows done");
      cmd(1'b1, 5'h1C, 8'hB8);
      chk("state", 8'(power_state), 8'(rsw_pkg::RSW_LOW_POWER));
      cmd(1'b1, 5'h01, 8'h02);
      chk("bank_a", 8'(bank_a), 8'h00);
      cmd(1'b1, 5'h1C, 8'h38);
      repeat (3) @(posedge ref_clk);
      chk("bank_a", 8'(bank_a), 8'h02);
      $display("test low power done");
      cmd(1'b1, 5'h1C, 8'h78);
      cmd(1'b1, 5'h1C, 8'hF8);
      chk("state", 8'(power_state), 8'(rsw_pkg::RSW_LOW_POWER));
      cmd(1'b0, 5'h01, 8'h00);
      chk("reg", rsp, 8'h00);
      cmd(1'b1, 5'h1C, 8'h00);
      cmd(1'b1, 5'h01, 8'h07);
      chk("bank_a", 8'(bank_a), 8'h00);
      cmd(1'b1, 5'h1C, 8'h01);
      repeat (3) @(posedge ref_clk);
      chk("bank_a", 8'(bank_a), 8'h07);
      cmd(1'b1, 5'h1A, 8'h80);
      chk("bank_a", 8'(bank_a), 8'h00);
      $display("test triggers done");
      vio_cycle_req <= 1'b1;
      wait_st(rsw_pkg::RSW_SHUTDOWN);
      vio_cycle_req <= 1'b0;
      wait_st(rsw_pkg::RSW_ACTIVE);
      cmd(1'b0, 5'h01, 8'h00);
      chk("reg", rsp, 8'h00);
      $display("test supply cycle done");
      end_of_test();
   end
endmodule : rffe_switch_slave_control_tb

//--- sim/rsw_assertions.sv
/* Checker of the serial link and of the device outputs.
 Assumes the bench wires it by name beside the link, on a 25 MHz ref_clk. */
`timescale 1ns/1ps
module rsw_checker (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Link
   input wire logic vio,
   input wire logic sclk,
   input wire logic m_sdata_out,
   input wire logic m_sdata_oe,
   input wire logic s_sdata_out,
   input wire logic s_sdata_oe,
   // Device
   input wire logic [rsw_pkg::PATH_W-1:0] antenna_common_first_bank,
   input wire logic charge_pump_on,
   input rsw_pkg::rsw_power_t power_state
);
   localparam rsw_pkg::rsw_power_t ACT = rsw_pkg::RSW_ACTIVE;
   localparam rsw_pkg::rsw_power_t STU = rsw_pkg::RSW_STARTUP;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // Outputs are flops, so one cycle of lag behind the state is tolerated.
   property p_pump;
      charge_pump_on |-> power_state == ACT || $past(power_state) == ACT;
   endproperty
   a_pump: assert property (p_pump) else $error("pump on outside active");
   property p_bank;
      power_state != ACT && $past(power_state) != ACT |-> antenna_common_first_bank == 5'h00;
   endproperty
   a_bank: assert property (p_bank) else $error("switch driven outside active");
   property p_shut; !vio [*5] |-> power_state == rsw_pkg::RSW_SHUTDOWN; endproperty
   a_shut: assert property (p_shut) else $error("not shut down with supply low");
   property p_entry; $rose(vio) |-> ##[1:6] power_state == STU; endproperty
   a_entry: assert property (p_entry) else $error("no startup on supply return");
   property p_settle; power_state == STU |-> ##[1:500] power_state != STU; endproperty
   a_settle: assert property (p_settle) else $error("startup too long");
   property p_rd;
      s_sdata_oe && $past(s_sdata_oe) && $changed(s_sdata_out) |-> !$past(sclk, 5);
   endproperty
   a_rd: assert property (p_rd) else $error("read data moved off rising edge");
   property p_wr; $fell(sclk) && m_sdata_oe && $past(m_sdata_oe) |-> $stable(m_sdata_out); endproperty
   a_wr: assert property (p_wr) else $error("data moved at falling edge");
   property p_low; $fell(vio) |-> ##249 !vio; endproperty
   a_low: assert property (p_low) else $error("supply low too short");
endmodule : rsw_checker
